/* File: pkg/switch_node_regs.svh */
`ifndef SWITCH_NODE_REGS_SVH
`define SWITCH_NODE_REGS_SVH

// register indices, byte address is four times the index
`define IDX_NODE_ID 8'h05
`define IDX_REF_DIV 8'h08
`define IDX_JTAG_ID 8'h09
`define IDX_USERCODE 8'h0a
`define IDX_DIR_LO 8'h0c
`define IDX_DIR_HI 8'h0d
`define IDX_DBG_CFG0 8'h10
`define IDX_DBG_CFG1 8'h11
`define IDX_DBG_SRC 8'h1f
`define IDX_LINK_BASE 8'h20
`define IDX_IRQ_STATUS 8'h30
`define IDX_IRQ_ENABLE 8'h31
`define IDX_IRQ_CLEAR 8'h32
`define IDX_PROCESSOR_LINK_BASE 8'h40

// apb word address field
`define ADDR_IDX_MSB 9
`define ADDR_IDX_LSB 2

// reset values
`define REF_DIV_RESET 16'h0003

// usercode fields
`define UC_OTP_LSB 18

// debug line configuration and source fields
`define DBG_DRIVE_EN_BIT 0
`define DBG_REQ_EN_BIT 1
`define DBG_SRC_PIN_BIT 4

// link status word fields
`define LNK_SRC_BUSY_BIT 0
`define LNK_DST_BUSY_BIT 1
`define LNK_JUNK_BIT 2
`define LNK_NET_LSB 4
`define LNK_NET_MSB 5
`define LNK_DIR_LSB 8
`define LNK_DIR_MSB 11
`define LNK_DEST_LSB 16
`define LNK_DEST_MSB 23
`define LNK_TGT_LSB 24
`define LNK_TGT_MSB 25

// interrupt status bits
`define IRQ_DEBUG_BIT 0
`define IRQ_JUNK_BIT 1
`define IRQ_LOCAL_BIT 2
`define IRQ_BITS 3

`endif

/* File: pkg/switch_node_pkg.sv */
package switch_node_pkg;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // apb answer of this slave
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // routing lookup request and answer
  typedef struct packed {
    logic valid;
    logic [15:0] dest_id;
  } route_req_t;

  typedef struct packed {
    logic valid;
    logic local_hit;
    logic [3:0] dir;
  } route_rsp_t;

  // source target kinds
  typedef enum logic [1:0] {
    TGT_SWITCH_LINK,
    TGT_PROCESSOR_LINK,
    TGT_SWITCH_CONTROL,
    TGT_UNDEFINED
  } target_type_t;

  // live state of one link from the fabric
  typedef struct packed {
    target_type_t source_target_type;
    logic [7:0] dest_link;
    logic junk;
    logic dest_busy;
    logic src_busy;
  } link_status_t;

endpackage : switch_node_pkg

/* File: hw/switch_node_cfg.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`include "switch_node_regs.svh"
// Behaviour
// - reference clock enable divides mclk by a 16-bit divider, reset three
// - usercode reads otp usercode high, metal id code low
// - low-byte mismatch routes by direction of most significant differing bit
// - upper-byte mismatch takes direction from second table
// - first table holds dimensions zero to seven, nibble each, reset zero
// - second table holds dimensions eight to fifteen, reset zero
// - per tile, bit one lets global debug line request core debug
// - per tile, bit zero lets in-debug flag drive global debug line
// - record last debug event source: pin bit four, cores bits one, zero
// - link status shows two-bit source target type
// - link status shows destination link number while in use
// - each switch link has writable direction field, reset zero
// - every link has writable two-bit network field, reset zero
// - junk bit shows while current packet is junk; packet discarded
// - dest-busy and source-busy flags per link
// - processor links have own status registers without direction
// - writable 16-bit node identifier, reset zero, used by routing
module switch_node_cfg #(
  parameter int NUM_SLINKS = 9,
  parameter int NUM_PLINKS = 8,
  parameter logic [31:0] JTAG_ID = 32'h0000_0001, // arbitrary value
  parameter logic [17:0] METAL_ID = 18'h0_0001 // arbitrary value
) (
  input wire logic mclk,
  input wire logic reset,
  input wire switch_node_pkg::apb_req_t apb_req,
  output switch_node_pkg::apb_rsp_t apb_rsp,
  input wire logic [13:0] otp_usercode,
  input wire switch_node_pkg::route_req_t route_req,
  output switch_node_pkg::route_rsp_t route_rsp,
  input wire logic [1:0] in_debug_flag,
  input wire logic debug_line_n_in,
  output logic debug_line_n_out,
  output logic debug_line_n_oe,
  output logic [1:0] core_debug_req,
  output logic ref_clk_en,
  input wire switch_node_pkg::link_status_t [NUM_SLINKS-1:0] switch_link_status,
  input wire switch_node_pkg::link_status_t [NUM_PLINKS-1:0] processor_link_status,
  output logic [NUM_SLINKS-1:0][3:0] switch_link_direction,
  output logic [NUM_SLINKS+NUM_PLINKS-1:0][1:0] link_network,
  output logic [NUM_SLINKS+NUM_PLINKS-1:0] link_discard,
  output logic irq
);
  import switch_node_pkg::*;

  localparam int NUM_LINKS = NUM_SLINKS + NUM_PLINKS;

  // whole state of the block
  typedef struct packed {
    logic [2:0] pin_sync;
    logic pin_n;
    logic glob_prev;
    logic [15:0] ref_div;
    logic [15:0] ref_cnt;
    logic ref_tick;
    logic [15:0] node_id;
    logic [7:0][3:0] dir_lo;
    logic [7:0][3:0] dir_hi;
    logic [1:0][1:0] dbg_cfg;
    logic [4:0] dbg_src;
    logic [1:0] core_req;
    logic line_oe;
    logic [NUM_SLINKS-1:0][3:0] link_dir;
    logic [NUM_LINKS-1:0][1:0] link_net;
    logic [NUM_LINKS-1:0] discard;
    logic [`IRQ_BITS-1:0] irq_status;
    logic [`IRQ_BITS-1:0] irq_enable;
    logic irq;
    route_rsp_t route;
    apb_rsp_t rsp;
  } state_t;

  state_t q;
  state_t d;

  // fabric view of all links, switch links first
  link_status_t [NUM_LINKS-1:0] all_status;
  assign all_status = {processor_link_status, switch_link_status};

  // status word of one link
  function automatic logic [31:0] link_word(
    input link_status_t s,
    input logic [3:0] dir,
    input logic [1:0] net
  );
    logic [31:0] w;
    w = '0; // reserved bits read zero
    w[`LNK_TGT_MSB:`LNK_TGT_LSB] = s.source_target_type;
    w[`LNK_DEST_MSB:`LNK_DEST_LSB] = s.dest_link;
    w[`LNK_DIR_MSB:`LNK_DIR_LSB] = dir;
    w[`LNK_NET_MSB:`LNK_NET_LSB] = net;
    w[`LNK_JUNK_BIT] = s.junk;
    w[`LNK_DST_BUSY_BIT] = s.dest_busy;
    w[`LNK_SRC_BUSY_BIT] = s.src_busy;
    return w;
  endfunction : link_word

  logic [7:0] idx;
  logic [7:0] switch_link_off;
  logic [7:0] processor_link_off;
  logic is_switch_link;
  logic is_processor_link;
  logic setup;
  logic take;
  logic mapped;
  logic [31:0] rdata;
  logic [31:0] wd;
  logic [15:0] diff;
  logic [3:0] msb;
  logic glob;
  logic drive;
  logic dbg_event;
  logic [4:0] src;
  logic [`IRQ_BITS-1:0] events;

  // next state
  always_comb begin
    d = q;
    idx = apb_req.paddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
    wd = apb_req.pwdata;
    switch_link_off = idx - `IDX_LINK_BASE;
    processor_link_off = idx - `IDX_PROCESSOR_LINK_BASE;
    is_switch_link = (idx >= `IDX_LINK_BASE) && (switch_link_off < 8'(NUM_SLINKS));
    is_processor_link = (idx >= `IDX_PROCESSOR_LINK_BASE) && (processor_link_off < 8'(NUM_PLINKS));
    setup = apb_req.psel && !apb_req.penable;
    take = apb_req.psel && apb_req.penable && q.rsp.pready;
    events = '0;

    // debug pin: three stages, change taken when last two agree
    d.pin_sync = {q.pin_sync[1:0], debug_line_n_in};
    if (q.pin_sync[2] == q.pin_sync[1]) begin
      d.pin_n = q.pin_sync[2];
    end

    // reference clock enable, one pulse every ref_div cycles
    d.ref_tick = 1'b0;
    if (q.ref_div == 16'h0000 || q.ref_cnt >= q.ref_div - 16'h0001) begin
      d.ref_cnt = '0;
      d.ref_tick = 1'b1;
    end else begin
      d.ref_cnt = q.ref_cnt + 16'h0001;
    end

    // routing lookup on the most significant differing bit
    diff = route_req.dest_id ^ q.node_id;
    msb = '0;
    for (int i = 0; i < 16; i++) begin
      if (diff[i]) begin
        msb = 4'(i);
      end
    end
    d.route.valid = route_req.valid;
    if (route_req.valid) begin
      d.route.local_hit = (diff == 16'h0000);
      if (diff == 16'h0000) begin
        d.route.dir = '0;
        events[`IRQ_LOCAL_BIT] = 1'b1;
      end else if (msb[3]) begin
        d.route.dir = q.dir_hi[msb[2:0]];
      end else begin
        d.route.dir = q.dir_lo[msb[2:0]];
      end
    end

    // global debug line: pin low means asserted, our own drive included
    glob = !q.pin_n;
    drive = 1'b0;
    for (int t = 0; t < 2; t++) begin
      if (in_debug_flag[t] && q.dbg_cfg[t][`DBG_DRIVE_EN_BIT]) begin
        drive = 1'b1;
      end
      d.core_req[t] = glob && q.dbg_cfg[t][`DBG_REQ_EN_BIT];
    end
    d.line_oe = drive;
    d.glob_prev = glob;
    dbg_event = glob && !q.glob_prev;
    src = '0;
    src[0] = in_debug_flag[0] && q.dbg_cfg[0][`DBG_DRIVE_EN_BIT];
    src[1] = in_debug_flag[1] && q.dbg_cfg[1][`DBG_DRIVE_EN_BIT];
    src[`DBG_SRC_PIN_BIT] = !(src[0] || src[1]);
    if (dbg_event) begin
      events[`IRQ_DEBUG_BIT] = 1'b1;
    end

    // junk flags feed discard outputs, rising junk raises an event
    for (int l = 0; l < NUM_LINKS; l++) begin
      d.discard[l] = all_status[l].junk;
    end
    if (|(d.discard & ~q.discard)) begin
      events[`IRQ_JUNK_BIT] = 1'b1;
    end

    // read mux, prepared in the setup cycle
    mapped = 1'b1;
    rdata = '0;
    if (is_switch_link) begin
      rdata = link_word(all_status[switch_link_off], q.link_dir[switch_link_off],
                        q.link_net[switch_link_off]);
    end else if (is_processor_link) begin
      rdata = link_word(all_status[NUM_SLINKS + int'(processor_link_off)], 4'h0,
                        q.link_net[NUM_SLINKS + int'(processor_link_off)]);
    end else begin
      case (idx)
        `IDX_NODE_ID: rdata[15:0] = q.node_id;
        `IDX_REF_DIV: rdata[15:0] = q.ref_div;
        `IDX_JTAG_ID: rdata = JTAG_ID;
        `IDX_USERCODE: rdata = {otp_usercode, METAL_ID};
        `IDX_DIR_LO: rdata = q.dir_lo;
        `IDX_DIR_HI: rdata = q.dir_hi;
        `IDX_DBG_CFG0: rdata[1:0] = q.dbg_cfg[0];
        `IDX_DBG_CFG1: rdata[1:0] = q.dbg_cfg[1];
        `IDX_DBG_SRC: rdata[4:0] = q.dbg_src;
        `IDX_IRQ_STATUS: rdata[`IRQ_BITS-1:0] = q.irq_status;
        `IDX_IRQ_ENABLE: rdata[`IRQ_BITS-1:0] = q.irq_enable;
        `IDX_IRQ_CLEAR: rdata = '0;
        default: mapped = 1'b0;
      endcase
    end

    // apb answer: ready one cycle, in the first access cycle
    d.rsp.pready = setup;
    if (setup) begin
      d.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
      d.rsp.pslverr = !mapped;
    end else if (take) begin
      d.rsp.prdata = '0;
      d.rsp.pslverr = 1'b0;
    end

    // register writes, read-only and reserved bits untouched
    if (take && apb_req.pwrite && mapped) begin
      if (is_switch_link) begin
        d.link_dir[switch_link_off] = wd[`LNK_DIR_MSB:`LNK_DIR_LSB];
        d.link_net[switch_link_off] = wd[`LNK_NET_MSB:`LNK_NET_LSB];
      end else if (is_processor_link) begin
        d.link_net[NUM_SLINKS + int'(processor_link_off)] = wd[`LNK_NET_MSB:`LNK_NET_LSB];
      end else begin
        case (idx)
          `IDX_NODE_ID: d.node_id = wd[15:0];
          `IDX_REF_DIV: d.ref_div = wd[15:0];
          `IDX_DIR_LO: d.dir_lo = wd;
          `IDX_DIR_HI: d.dir_hi = wd;
          `IDX_DBG_CFG0: d.dbg_cfg[0] = wd[1:0];
          `IDX_DBG_CFG1: d.dbg_cfg[1] = wd[1:0];
          `IDX_DBG_SRC: begin
            d.dbg_src[0] = wd[0];
            d.dbg_src[1] = wd[1];
            d.dbg_src[`DBG_SRC_PIN_BIT] = wd[`DBG_SRC_PIN_BIT];
          end
          `IDX_IRQ_ENABLE: d.irq_enable = wd[`IRQ_BITS-1:0];
          `IDX_IRQ_CLEAR: d.irq_status = q.irq_status & ~wd[`IRQ_BITS-1:0];
          default: d.node_id = q.node_id; // read-only registers
        endcase
      end
    end

    // a new debug event wins over a software write of the source
    if (dbg_event) begin
      d.dbg_src = src;
    end

    // sticky status, set wins over clear
    d.irq_status = d.irq_status | events;
    d.irq = |(d.irq_status & d.irq_enable);
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.pin_sync <= 3'h7;
      q.pin_n <= 1'b1;
      q.ref_div <= `REF_DIV_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register, except debug_line_n_out which is tied low
  assign apb_rsp = q.rsp;
  assign route_rsp = q.route;
  assign debug_line_n_out = 1'b0; // open drain: only ever pulls low
  assign debug_line_n_oe = q.line_oe;
  assign core_debug_req = q.core_req;
  assign ref_clk_en = q.ref_tick;
  assign switch_link_direction = q.link_dir;
  assign link_network = q.link_net;
  assign link_discard = q.discard;
  assign irq = q.irq;

endmodule : switch_node_cfg

/* File: testbench/switch_node_cfg_assertions.sv */
`timescale 1ns/100ps
module switch_node_checker
  import switch_node_pkg::*;
#(
  parameter int NUM_SLINKS = 9,
  parameter int NUM_PLINKS = 8
) (
  input wire logic mclk,
  input wire logic reset,
  input wire switch_node_pkg::apb_req_t apb_req,
  input wire switch_node_pkg::apb_rsp_t apb_rsp,
  input wire switch_node_pkg::route_req_t route_req,
  input wire switch_node_pkg::route_rsp_t route_rsp,
  input wire logic [1:0] in_debug_flag,
  input wire logic debug_line_n_in,
  input wire logic debug_line_n_oe,
  input wire logic [1:0] core_debug_req,
  input wire logic ref_clk_en,
  input wire switch_node_pkg::link_status_t [NUM_SLINKS-1:0] switch_link_status,
  input wire logic [NUM_SLINKS+NUM_PLINKS-1:0] link_discard,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // lookup answers, bus timing, debug line and link relations
  a_route_answer_next: assert property (route_req.valid |=> route_rsp.valid) else $error("route late");
  a_route_no_spurious: assert property (route_rsp.valid |-> $past(route_req.valid)) else $error("route unasked");
  a_local_dir_zero: assert property (route_rsp.valid && route_rsp.local_hit |-> route_rsp.dir == 4'h0)
    else $error("local dir");
  a_discard_tracks_junk: assert property (!$past(reset) |-> link_discard[0] == $past(switch_link_status[0].junk))
    else $error("discard");
  a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("pready");
  a_error_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready) else $error("pslverr");
  a_drive_needs_flag: assert property (debug_line_n_oe |-> $past(in_debug_flag) != 2'h0) else $error("oe");
  a_request_needs_pin: assert property ($rose(core_debug_req[0]) |-> !$past(debug_line_n_in, 3))
    else $error("core req");
  a_ref_pulse_single: assert property (ref_clk_en |=> !ref_clk_en) else $error("ref pulse");
  c_local: cover property (route_rsp.valid && route_rsp.local_hit);
  c_error: cover property (apb_rsp.pslverr);
  c_irq: cover property ($rose(irq));
  c_core: cover property ($rose(core_debug_req[0]));
endmodule : switch_node_checker

bind switch_node_cfg switch_node_checker #(.NUM_SLINKS(NUM_SLINKS), .NUM_PLINKS(NUM_PLINKS)) switch_node_checker_i (
  .mclk(mclk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp), .route_req(route_req),
  .route_rsp(route_rsp), .in_debug_flag(in_debug_flag), .debug_line_n_in(debug_line_n_in),
  .debug_line_n_oe(debug_line_n_oe), .core_debug_req(core_debug_req), .ref_clk_en(ref_clk_en),
  .switch_link_status(switch_link_status), .link_discard(link_discard), .irq(irq));

/* File: testbench/switch_fabric_model.sv */
`timescale 1ns/100ps
module switch_fabric_model
  import switch_node_pkg::*;
#(
  parameter int NUM_SLINKS = 9,
  parameter int NUM_PLINKS = 8
) (
  input wire logic debug_line_n_oe,
  input wire logic pin_pull,
  input wire logic junk0,
  output switch_node_pkg::link_status_t [NUM_SLINKS-1:0] switch_link_status,
  output switch_node_pkg::link_status_t [NUM_PLINKS-1:0] processor_link_status,
  output logic debug_line_n_in
);
  // open-drain line with pull-up, low while anyone pulls
  assign debug_line_n_in = !(debug_line_n_oe || pin_pull);
  // links: fixed destinations, processor links walk every target kind
  always_comb begin
    for (int i = 0; i < NUM_SLINKS; i++) begin
      switch_link_status[i] = '{TGT_SWITCH_LINK, 8'(5 + i), (i == 0) && junk0, 1'h1, 1'h1};
    end
    for (int j = 0; j < NUM_PLINKS; j++) begin
      processor_link_status[j] = '{target_type_t'(j[1:0]), 8'(3 + j), 1'h0, 1'h1, 1'h0};
    end
  end
endmodule : switch_fabric_model

/* File: testbench/test_switch_node_routing_debug_config.sv */
`timescale 1ns/100ps
module test_switch_node_routing_debug_config;
  import switch_node_pkg::*;
  localparam int NS = 9;
  localparam int NP = 8;
  localparam logic [17:0] METAL_ID = 18'h0_0123; // arbitrary value
  localparam logic [13:0] OTP = 14'h2a5;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic pin_pull = 1'h0;
  logic junk0 = 1'h0;
  logic [1:0] in_debug_flag = 2'h0;
  apb_req_t apb_req = '0;
  route_req_t route_req = '0;
  apb_rsp_t apb_rsp;
  route_rsp_t route_rsp;
  link_status_t [NS-1:0] switch_link_status;
  link_status_t [NP-1:0] processor_link_status;
  logic debug_line_n_in, debug_line_n_out, debug_line_n_oe, ref_clk_en, irq;
  logic [1:0] core_debug_req;
  logic [NS-1:0][3:0] switch_link_direction;
  logic [NS+NP-1:0][1:0] link_network;
  logic [NS+NP-1:0] link_discard;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;
  typedef struct packed {logic wr; logic [7:0] idx; logic [31:0] wd; logic [31:0] exp; logic err;} row_t;
  // optional write, then read back
  row_t rows [16] = '{
    '{1'h0, 8'h08, 32'h0, 32'h3, 1'h0},
    '{1'h0, 8'h0c, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h0d, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h05, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h1f, 32'h0, 32'h0, 1'h0},
    '{1'h1, 8'h08, 32'hffff_0005, 32'h5, 1'h0},
    '{1'h1, 8'h0c, 32'h7654_3210, 32'h7654_3210, 1'h0},
    '{1'h1, 8'h0d, 32'hfedc_ba98, 32'hfedc_ba98, 1'h0},
    '{1'h1, 8'h05, 32'hffff_1234, 32'h1234, 1'h0},
    '{1'h1, 8'h10, 32'hffff_ffff, 32'h3, 1'h0},
    '{1'h1, 8'h11, 32'hffff_fffe, 32'h2, 1'h0},
    '{1'h1, 8'h0a, 32'hffff_ffff, {OTP, METAL_ID}, 1'h0},
    '{1'h1, 8'h3f, 32'h1, 32'h0, 1'h1},
    '{1'h0, 8'h20, 32'h0, 32'h0005_0003, 1'h0},
    '{1'h1, 8'h20, 32'hffff_ffff, 32'h0005_0f33, 1'h0},
    '{1'h1, 8'h40, 32'hffff_ffff, 32'h0003_0032, 1'h0}};

  switch_node_cfg #(.NUM_SLINKS(NS), .NUM_PLINKS(NP), .METAL_ID(METAL_ID)) switch_node_cfg_i (
    .mclk(mclk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp), .otp_usercode(OTP),
    .route_req(route_req), .route_rsp(route_rsp), .in_debug_flag(in_debug_flag),
    .debug_line_n_in(debug_line_n_in), .debug_line_n_out(debug_line_n_out), .debug_line_n_oe(debug_line_n_oe),
    .core_debug_req(core_debug_req), .ref_clk_en(ref_clk_en), .switch_link_status(switch_link_status),
    .processor_link_status(processor_link_status), .switch_link_direction(switch_link_direction), .link_network(link_network),
    .link_discard(link_discard), .irq(irq));
  switch_fabric_model #(.NUM_SLINKS(NS), .NUM_PLINKS(NP)) switch_fabric_model_i (
    .debug_line_n_oe(debug_line_n_oe), .pin_pull(pin_pull), .junk0(junk0),
    .switch_link_status(switch_link_status), .processor_link_status(processor_link_status), .debug_line_n_in(debug_line_n_in));

  // clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, result left in rd and er
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk) apb_req <= '{1'h1, 1'h0, w, {2'h0, i, 2'h0}, d};
    @(posedge mclk) apb_req.penable <= 1'h1;
    @(posedge mclk);
    // answer sampled at the edge where pready is seen high, request released there
    while (apb_rsp.pready !== 1'h1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    if (n == 20) mismatches++;
    apb_req <= '0;
  endtask : apb

  task automatic route(input logic [15:0] d, input logic hit, input logic [3:0] dir);
    @(posedge mclk) route_req <= '{1'h1, d};
    @(posedge mclk) route_req.valid <= 1'h0;
    #1;
    chk({26'h0, route_rsp.valid, route_rsp.local_hit, route_rsp.dir}, {26'h0, 1'h1, hit, dir});
  endtask : route

  task automatic refcount(input int cyc, input int exp);
    int n;
    n = 0;
    repeat (cyc) begin
      @(posedge mclk) #1;
      if (ref_clk_en === 1'h1) n++;
    end
    chk(32'(n), 32'(exp));
  endtask : refcount

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic conclude();
    $display("cmp_count=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'h0;
    refcount(30, 10);
    foreach (rows[k]) begin
      if (rows[k].wr) apb(1'h1, rows[k].idx, rows[k].wd);
      apb(1'h0, rows[k].idx, 32'h0);
      chk(rd, rows[k].exp);
      chk({31'h0, er}, {31'h0, rows[k].err});
    end
    for (int j = 1; j < 4; j++) begin
      apb(1'h0, 8'h40 + 8'(j), 32'h0);
      chk(rd, {6'h0, 2'(j), 8'(3 + j), 16'h0002});
    end
    chk({24'h0, switch_link_direction[0], link_network[0], link_network[NS]}, 32'hff);
    $display("register tests done");
    route(16'h1234, 1'h1, 4'h0);
    route(16'h1235, 1'h0, 4'h0);
    route(16'h12b4, 1'h0, 4'h7);
    route(16'h1334, 1'h0, 4'h8);
    route(16'h92ff, 1'h0, 4'hf);
    refcount(50, 10);
    $display("routing tests done");
    apb(1'h1, 8'h32, 32'h7);
    apb(1'h1, 8'h31, 32'h1);
    in_debug_flag <= 2'h3;
    settle(10);
    chk({28'h0, debug_line_n_oe, irq, core_debug_req}, 32'hf);
    apb(1'h0, 8'h1f, 32'h0);
    chk(rd, 32'h1);
    in_debug_flag <= 2'h0;
    settle(8);
    apb(1'h1, 8'h32, 32'h7);
    settle(1);
    chk({28'h0, debug_line_n_oe, irq, core_debug_req}, 32'h0);
    pin_pull <= 1'h1;
    settle(10);
    apb(1'h0, 8'h1f, 32'h0);
    chk(rd, 32'h10);
    chk({30'h0, core_debug_req}, 32'h3);
    pin_pull <= 1'h0;
    settle(8);
    apb(1'h1, 8'h32, 32'h7);
    apb(1'h1, 8'h31, 32'h0);
    junk0 <= 1'h1;
    settle(3);
    chk({30'h0, irq, link_discard[0]}, 32'h1);
    apb(1'h0, 8'h20, 32'h0);
    chk(rd, 32'h0005_0f37);
    apb(1'h0, 8'h30, 32'h0);
    chk(rd, 32'h2);
    apb(1'h1, 8'h31, 32'h2);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, 8'h32, 32'h2);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    $display("debug and junk tests done");
    reset <= 1'h1;
    settle(2);
    reset <= 1'h0;
    apb(1'h0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    chk({28'h0, switch_link_direction[0]}, 32'h0);
    chk({31'h0, debug_line_n_out}, 32'h0);
    $display("reset test done");
    conclude();
  end
endmodule : test_switch_node_routing_debug_config
